// ===== bst_ctl.sv
// bst_ctl: outside scan tester driving the test pins.
// assumes: tdo line pulled high while the tap releases it.
module bst_ctl (
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trstN,
  input wire logic tdo,
  input wire logic tdoOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1;
  end
  // one 160 ns period; mode and data change well away from the rise
  task automatic step(input logic m, input logic x, output logic v);
    tms = m;
    tdi = x;
    #40 tck = 1'b1;
    #40 v = tdoOe ? tdo : 1'b1;
    #40 tck = 1'b0;
    #40;
  endtask
  // tap reset ahead of any fifo use, with recovery before the first clock
  task automatic hold_reset();
    trstN = 1'b0;
    #200 trstN = 1'b1;
    #100;
  endtask
endmodule

// ===== bst_edge.sv
// bst_edge: finds rising and falling edges of a synchronised test clock.
// assumes: input already passed a synchroniser on clk.
module bst_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);
  import bst_pkg::*;

  typedef struct packed {
    logic last;
  } bst_edge_t;

  bst_edge_t st_ff;
  bst_edge_t nxt_st;

  // remember last level to compare against
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.last = lvl;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rise = lvl & ~st_ff.last;
  assign fall = ~lvl & st_ff.last;
endmodule

// ===== bst_pkg.sv
// bst_pkg: constants and types shared by the boundary-scan tap files.
// assumes: included before every bst_ module; no other dependency.
package bst_pkg;

  // instruction register
  localparam int          IR_W          = 4;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;     // low two bits fixed 01
  localparam logic [3:0]  OP_EXTEST     = 4'h0;
  localparam logic [3:0]  OP_SAMPLE     = 4'h1;
  localparam logic [3:0]  OP_IDCODE     = 4'h2;
  localparam logic [3:0]  OP_HIGHZ      = 4'h3;
  localparam logic [3:0]  OP_BYPASS     = 4'hF;
  localparam logic [3:0]  OP_RESET_LOAD = OP_IDCODE;

  // identification word layout
  localparam int          ID_W          = 32;
  localparam int          ID_VER_LSB    = 28;
  localparam int          ID_PART_LSB   = 12;
  localparam int          ID_MAKER_LSB  = 1;
  // neutral identity values, arbitrary
  localparam logic [3:0]  ID_VERSION    = 4'h1;
  localparam logic [15:0] ID_PART       = 16'h1234;
  localparam logic [10:0] ID_MAKER      = 11'h055;
  localparam logic [31:0] ID_WORD       = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // boundary chain length, no figure given
  localparam int          BSR_W         = 8;

  // link timing, test clock period figure and its minimum count of clk cycles
  localparam int          CLK_NS        = 20;
  localparam int          TCK_MIN_NS    = 100;
  localparam int          TCK_MIN_CYC   = (TCK_MIN_NS + CLK_NS - 1) / CLK_NS;

  // five high mode-select edges always reach reset
  localparam int          RESET_EDGES   = 5;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;

  // next tap state on one rising test clock edge
  function automatic bst_state_t bst_next(input bst_state_t s, input logic m);
    case (s)
      ST_RESET:  bst_next = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   bst_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: bst_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: bst_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  bst_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: bst_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: bst_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: bst_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: bst_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: bst_next = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: bst_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  bst_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: bst_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: bst_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: bst_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: bst_next = m ? ST_SEL_DR : ST_IDLE;
      default:   bst_next = ST_RESET;
    endcase
  endfunction

endpackage

// ===== bst_sync.sv
// bst_sync: two-stage synchroniser for one level from outside clk.
// assumes: clk free running; rst asynchronous active high.
module bst_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  import bst_pkg::*;

  typedef struct packed {
    logic meta;
    logic held;
  } bst_sync_t;

  bst_sync_t st_ff;
  bst_sync_t nxt_st;

  // first stage is read only by the second
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = din;
    nxt_st.held = st_ff.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.held;
endmodule

// ===== bst_tap.sv
// bst_tap: boundary-scan test access port with tap controller, instruction
// register, bypass, identification and boundary chain registers.
// assumes: test pins are asynchronous to clk and sampled here; test clock is
// much slower than clk (at least TCK_MIN_CYC clk periods).
module bst_tap (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  input  wire logic                      trstN,
  output logic                           tdo,
  output logic                           tdoOe,
  input  wire logic [bst_pkg::BSR_W-1:0] pinIn,
  input  wire logic [bst_pkg::BSR_W-1:0] coreOut,
  output logic      [bst_pkg::BSR_W-1:0] padOut,
  output logic                           padOe,
  output logic                           fifoEnable,
  output logic                           testReset
);
  import bst_pkg::*;

  typedef struct packed {
    logic              seeded;
    bst_state_t        state;
    logic [IR_W-1:0]   irShift;
    logic [IR_W-1:0]   irCur;
    logic              byp;
    logic [ID_W-1:0]   idShift;
    logic [BSR_W-1:0]  bsShift;
    logic [BSR_W-1:0]  bsUpd;
    logic              tdoBit;
    logic              tdoEn;
    logic              trstSeen;
  } bst_tap_t;

  bst_tap_t st_ff;
  bst_tap_t nxt_st;

  logic tckS;
  logic tmsS;
  logic tdiS;
  logic trstNS;
  logic trstAct;
  logic tckRise;
  logic tckFall;
  logic selBsr;
  logic selId;
  logic serialOut;

  // every test pin crosses into clk through two flops
  bst_sync uSyncTck  (.clk(clk), .rst(rst), .din(tck),   .dout(tckS));
  bst_sync uSyncTms  (.clk(clk), .rst(rst), .din(tms),   .dout(tmsS));
  bst_sync uSyncTdi  (.clk(clk), .rst(rst), .din(tdi),   .dout(tdiS));
  // inverted through the sync so cleared flops mean idle, not a false test reset
  bst_sync uSyncTrst (.clk(clk), .rst(rst), .din(~trstN), .dout(trstAct));
  assign trstNS = ~trstAct;

  bst_edge uEdge (
    .clk  (clk),
    .rst  (rst),
    .lvl  (tckS),
    .rise (tckRise),
    .fall (tckFall)
  );

  // register select from the current instruction
  assign selBsr = (st_ff.irCur == OP_EXTEST) || (st_ff.irCur == OP_SAMPLE);
  assign selId  = (st_ff.irCur == OP_IDCODE);

  // serial output mux; unknown codes fall back to bypass
  always_comb begin
    if (st_ff.state == ST_SH_IR) begin
      serialOut = st_ff.irShift[0];
    end else if (selBsr) begin
      serialOut = st_ff.bsShift[0];
    end else if (selId) begin
      serialOut = st_ff.idShift[0];
    end else begin
      serialOut = st_ff.byp;
    end
  end

  // controller and registers, stepped by detected test clock edges
  always_comb begin
    nxt_st = st_ff;
    if (!trstNS) begin
      // held test reset wins over any clock edge
      nxt_st.state    = ST_RESET;
      nxt_st.irCur    = OP_RESET_LOAD;
      nxt_st.tdoEn    = 1'b0;
      nxt_st.seeded   = 1'b1;
      nxt_st.trstSeen = 1'b1;
    end else if (tckRise) begin
      nxt_st.seeded = 1'b1;
      nxt_st.state  = bst_next(st_ff.state, tmsS);
      case (st_ff.state)
        ST_RESET: begin
          nxt_st.irCur = OP_RESET_LOAD;
        end
        ST_CAP_IR: begin
          nxt_st.irShift = IR_CAPTURE;
        end
        ST_SH_IR: begin
          nxt_st.irShift = {tdiS, st_ff.irShift[IR_W-1:1]};
        end
        ST_CAP_DR: begin
          // only the selected register loads
          if (selBsr) begin
            nxt_st.bsShift = (st_ff.irCur == OP_EXTEST) ? pinIn : coreOut;
          end else if (selId) begin
            nxt_st.idShift = ID_WORD;
          end else begin
            nxt_st.byp = 1'b0;
          end
        end
        ST_SH_DR: begin
          if (selBsr) begin
            nxt_st.bsShift = {tdiS, st_ff.bsShift[BSR_W-1:1]};
          end else if (selId) begin
            nxt_st.idShift = {tdiS, st_ff.idShift[ID_W-1:1]};
          end else begin
            nxt_st.byp = tdiS;
          end
        end
        default: begin
          // idle, pause and select states hold all registers
          nxt_st.irShift = st_ff.irShift;
        end
      endcase
    end else if (tckFall) begin
      // output and latches move on the falling edge
      nxt_st.tdoBit = serialOut;
      nxt_st.tdoEn  = (st_ff.state == ST_SH_IR) || (st_ff.state == ST_SH_DR);
      if (st_ff.state == ST_UPD_IR) begin
        nxt_st.irCur = st_ff.irShift;
      end
      if (st_ff.state == ST_UPD_DR && selBsr) begin
        nxt_st.bsUpd = st_ff.bsShift;
      end
    end
  end

  // rst clears every tap register too; state reads reset but stays unseeded until trst or a test clock rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // test reset output held low until first trst or test clock rise seen
  assign testReset  = st_ff.seeded && (st_ff.state == ST_RESET);
  assign fifoEnable = testReset;
  assign tdo        = st_ff.tdoBit;
  assign tdoOe      = st_ff.tdoEn;

  // pads: extest drives chain values, high-z turns all off
  assign padOut = (st_ff.irCur == OP_EXTEST && !testReset) ? st_ff.bsUpd : coreOut;
  assign padOe  = !(st_ff.irCur == OP_HIGHZ && !testReset);
endmodule

// ===== bst_tap_asserts.sv
// bst_tap_asserts: pin timing and mode checks on the tap.
// assumes: bound to bst_tap; test clock far slower than clk.
module bst_tap_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       trstN,
  input wire logic       tdo,
  input wire logic       tdoOe,
  input wire logic [7:0] coreOut,
  input wire logic [7:0] padOut,
  input wire logic       padOe,
  input wire logic       fifoEnable,
  input wire logic       testReset
);
  logic       tckQ;
  logic [3:0] fallAge;
  logic [3:0] riseAge;
  logic [2:0] ones;
  // clk cycles since raw test clock edges, saturating so idle gaps never wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      {tckQ, fallAge, riseAge, ones} <= 12'h7F8;
    else begin
      tckQ    <= tck;
      fallAge <= (!tck && tckQ) ? 4'h0 : fallAge + 4'(fallAge != 4'hF);
      riseAge <= (tck && !tckQ) ? 4'h0 : riseAge + 4'(riseAge != 4'hF);
      if (tck && !tckQ)
        ones <= tms ? ones + 3'(ones != 3'h5) : 3'h0;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // reset paths first, then output timing against the test clock edges
  sequence s_trst; !trstN [*6]; endsequence
  sequence s_five; $changed(ones) && ones == 3'h5; endsequence
  property p_trst; s_trst |-> fifoEnable && !tdoOe; endproperty
  property p_five; s_five |-> ##[1:5] fifoEnable; endproperty
  property p_edge; $changed(tdo) || $rose(tdoOe) |-> fallAge inside {[1:6]}; endproperty
  property p_move; $fell(fifoEnable) |-> riseAge inside {[1:6]}; endproperty
  property p_pad; fifoEnable |-> padOe && padOut == coreOut; endproperty
  property p_hz; !padOe |-> !fifoEnable; endproperty
  property p_same; $rose(testReset) |-> tms || !trstN; endproperty
  property p_quiet; fifoEnable |-> !tdoOe; endproperty
  a_trst: assert property (p_trst) else $error("tap not reset by trst");
  a_five: assert property (p_five) else $error("five ones missed reset");
  a_edge: assert property (p_edge) else $error("tdo moved off a fall");
  a_move: assert property (p_move) else $error("state left reset without rise");
  a_pad: assert property (p_pad) else $error("pads not normal in reset");
  a_hz: assert property (p_hz) else $error("pads off in reset");
  a_same: assert property (p_same) else $error("reset entered without cause");
  a_quiet: assert property (p_quiet) else $error("tdo driven in reset");
endmodule

bind bst_tap bst_tap_asserts bst_tap_asserts_inst (.*);

// ===== bst_tap_tb.sv
// bst_tap_tb: scan tap scenarios driven through a modelled tester.
// assumes: bst_pkg, bst_ctl and the checker compiled ahead of it.
module bst_tap_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bst_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tck, tms, tdi, trstN, tdo, tdoOe, padOe, fifoEnable, testReset, q;
  logic [7:0]  pinIn = 8'h5A;
  logic [7:0]  coreOut = 8'h96;
  logic [7:0]  padOut;
  logic [31:0] d;
  int          errors = 0;
  int          checksDone = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  bst_tap bst_tap_inst (.*);
  bst_ctl bst_ctl_inst (.*);
  // compare and count, four-state exact
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic st(input logic m, input logic x);
    bst_ctl_inst.step(m, x, q);
  endtask
  // idle to scan, n bits lsb first, optional pause after bit 1, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic pz);
    d = '0;
    st('1, '0);
    if (ir)
      st('1, '0);
    st('0, '0);
    st('0, '0);
    for (int i = 0; i < n; i++) begin
      st(i == n - 1 || (pz && i == 1), din[i]);
      d[i] = q;
      if (pz && i == 1) begin
        st('0, ~din[i]);
        st('0, din[i]);
        check(tdoOe, 1'b0);
        st('1, ~din[i]);
        st('0, din[i]);
      end
    end
    st('1, '0);
    st('0, '0);
  endtask
  task automatic ir_load(input logic [3:0] op, input logic pz);
    scan('1, 4, 32'(op), pz);
    check(d, 32'(IR_CAPTURE));
  endtask
  // trst brings the tap up in reset holding the id instruction
  task automatic t_trst();
    check(fifoEnable, 1'b0);
    bst_ctl_inst.hold_reset();
    check(fifoEnable, 1'b1);
    st('0, '0);
    check(fifoEnable, 1'b0);
    scan('0, 32, '0, '0);
    check(d, ID_WORD);
  endtask
  // preload under sample, then drive and capture the pins under extest
  task automatic t_chain();
    ir_load(OP_SAMPLE, '1);
    scan('0, 8, 32'h0000_00C3, '0);
    check(d, 32'(coreOut));
    ir_load(OP_EXTEST, '0);
    check(padOut, 8'hC3);
    scan('0, 8, '0, '1);
    check(d, 32'(pinIn));
  endtask
  // bypass, an unused code and high-z all give one stage that captures zero
  task automatic t_bypass();
    logic [3:0] ops [3] = '{OP_BYPASS, 4'h7, OP_HIGHZ};
    foreach (ops[k]) begin
      ir_load(ops[k], '0);
      scan('0, 8, 32'h0000_00A5, '0);
      check(d, 32'h0000_004A);
      check(padOe, ops[k] != OP_HIGHZ);
    end
  endtask
  // five high mode-select clocks reset the tap, pads and id path return
  task automatic t_five();
    repeat (5)
      st('1, '0);
    check(fifoEnable, 1'b1);
    check(padOe, 1'b1);
    st('0, '0);
    scan('0, 32, '0, '0);
    check(d, ID_WORD);
  endtask
  // hang guard, far above the seventeen hundred or so cycles needed
  always @(posedge clk)
    if (++cycles == 9000) begin
      errors++;
      print_verdict();
    end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    t_trst();
    t_chain();
    t_bypass();
    t_five();
    print_verdict();
  end
endmodule
